// file: hdl/sctc_div_decode.sv
/*
 * Decoder of the clock tree configuration codes into division and
 * multiplication factors, registered at its output.
 * Assumes the codes come from registers on the same clock.
 */
module sctc_div_decode (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [5:0] mul_code,
	input wire logic [3:0] ahb_code,
	input wire logic [2:0] apb1_code,
	input wire logic [2:0] apb2_code,
	input wire logic [3:0] adc_code,
	input wire logic pll_div,
	input wire logic pll_src,
	input wire logic pll_presel,
	output sctc_pkg::sctc_tree_s tree
);

	sctc_pkg::sctc_tree_s tree_ff;
	sctc_pkg::sctc_tree_s nxt_tree;

	function automatic logic [4:0] apb_div(input logic [2:0] code);
		logic [4:0] d;
		d = 5'h01;
		if (code[2]) begin
			d = 5'(5'h02 << code[1:0]);
		end
		return d;
	endfunction

	always_comb begin
		nxt_tree = '0;
		if (mul_code <= 6'h0e) begin
			nxt_tree.mul_factor = 6'(mul_code + 6'h02);
		end else if (mul_code == 6'h0f) begin
			nxt_tree.mul_factor = 6'h10;
		end else if (mul_code == 6'h3f) begin
			nxt_tree.mul_factor = 6'h3f;
		end else begin
			nxt_tree.mul_factor = 6'(mul_code + 6'h01);
		end
		unique case (ahb_code)
			4'h8: nxt_tree.ahb_div = 10'h002;
			4'h9: nxt_tree.ahb_div = 10'h004;
			4'ha: nxt_tree.ahb_div = 10'h008;
			4'hb: nxt_tree.ahb_div = 10'h010;
			4'hc: nxt_tree.ahb_div = 10'h040;
			4'hd: nxt_tree.ahb_div = 10'h080;
			4'he: nxt_tree.ahb_div = 10'h100;
			4'hf: nxt_tree.ahb_div = 10'h200;
			default: nxt_tree.ahb_div = 10'h001;
		endcase
		nxt_tree.apb1_div = apb_div(apb1_code);
		nxt_tree.apb2_div = apb_div(apb2_code);
		nxt_tree.adc_from_ahb = adc_code[3];
		unique case ({adc_code[3], adc_code[1:0]})
			3'h4: nxt_tree.adc_div = 5'h05;
			3'h5: nxt_tree.adc_div = 5'h06;
			3'h6: nxt_tree.adc_div = 5'h0a;
			3'h7: nxt_tree.adc_div = 5'h14;
			default: begin
				unique case (adc_code[2:0])
					3'h0: nxt_tree.adc_div = 5'h02;
					3'h1: nxt_tree.adc_div = 5'h04;
					3'h2: nxt_tree.adc_div = 5'h06;
					3'h3: nxt_tree.adc_div = 5'h08;
					3'h4: nxt_tree.adc_div = 5'h02;
					3'h5: nxt_tree.adc_div = 5'h0c;
					3'h6: nxt_tree.adc_div = 5'h08;
					3'h7: nxt_tree.adc_div = 5'h10;
				endcase
			end
		endcase
		nxt_tree.pll_div2 = pll_div;
		// 00: RC8M/2, 01: crystal, 10: RC48M
		nxt_tree.pll_input = pll_src ? {pll_presel, ~pll_presel} : 2'b00;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			tree_ff <= '0;
		end else begin
			tree_ff <= nxt_tree;
		end
	end

	assign tree = tree_ff;

endmodule

// file: hdl/sctc_pkg.sv
/*
 * Package of the system clock tree control block: register offsets, field
 * positions, reset values, switch encodings and structs.
 * Assumes a classic Wishbone slave with 32-bit data and byte addresses.
 */
// Functional notes
// - Multiplier codes 0..14 give code+2; code 15 also gives sixteen.
// - Multiplier codes from 16 give code+1; codes 62 and 63 give 63.
// - Pre-divide bit 0 passes the PLL input; 1 divides it by two.
// - PLL source 0 takes RC8M/2; 1 takes crystal or RC48M by preselect.
// - ADC codes 0..7 divide APB2 clock by 2,4,6,8,2,12,8,16.
// - ADC codes 1x00..1x11 divide AHB clock by 5,6,10,20.
// - APB2 codes 0xx undivided; 100..111 divide AHB by 2,4,8,16.
// - APB1 codes 0xx undivided; 100..111 divide AHB by 2,4,8,16.
// - AHB codes 0xxx undivided; 1000..1111 divide by 2..512.
// - Status field reports active source: RC8M, crystal, PLL; 11 reserved.
// - Software switch field selects the source; switch completes with latency.
// - Wake from deep-sleep/standby, or crystal failure while the crystal is in use, forces RC8M.
// - Interrupt register lives at 0x08 and resets to zero.
// - Writing 1 to bit 23 clears the crystal-stuck flag; 0 no effect.
// - Writing 1 to bits 20..16 clears the matching stable flag.
// - Read-write stable interrupt enables sit at bits 12..8.
// - Stable flags at bits 4..0 set on stable with enable; sticky.
// - Crystal-stuck flag at bit 7 sets on stuck; cleared only by bit 23.
package sctc_pkg;

	localparam logic [7:0] CFG0_ADDR = 8'h04;
	localparam logic [7:0] INT_ADDR = 8'h08;
	localparam logic [7:0] CFG1_ADDR = 8'h2c;
	localparam logic [7:0] CTRL_ADDR = 8'h30;

	localparam logic [31:0] CFG0_RESET = 32'h0000_0000;
	localparam logic [31:0] INT_RESET = 32'h0000_0000;
	localparam logic [31:0] CFG1_RESET = 32'h0000_0000;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

	// Configuration zero field positions
	localparam int SW_LSB = 0;
	localparam int SWS_LSB = 2;
	localparam int AHB_LSB = 4;
	localparam int APB1_LSB = 8;
	localparam int APB2_LSB = 11;
	localparam int ADC_LSB = 14;
	localparam int PSRC_BIT = 16;
	localparam int PDIV_BIT = 17;
	localparam int MUL_LSB = 18;
	localparam int MUL4_BIT = 27;
	localparam int ADC2_BIT = 28;
	localparam int MUL5_BIT = 30;
	// Configuration one field positions
	localparam int ADC3_BIT = 29;
	localparam int PRESEL_BIT = 30;
	// Interrupt register field positions
	localparam int FLAG_LSB = 0;
	localparam int STUCK_FLAG_BIT = 7;
	localparam int EN_LSB = 8;
	localparam int CLR_LSB = 16;
	localparam int STUCK_CLR_BIT = 23;
	// Control register: PLL enable
	localparam int PLL_EN_BIT = 0;
	localparam int NSRC = 5;

	// Write mask of writable bits per register
	localparam logic [31:0] CFG0_WMASK = 32'h5c3f_fff3;
	localparam logic [31:0] CFG1_WMASK = 32'h6000_0000;
	localparam logic [31:0] CTRL_WMASK = 32'h0000_0001;

	// Cycles the old clock is held off before the new source is used
	localparam logic [3:0] SWITCH_GAP = 4'h4;

	typedef enum logic [1:0] {
		SCTC_SRC_RC8M = 2'b00,
		SCTC_SRC_XTAL = 2'b01,
		SCTC_SRC_PLL = 2'b10,
		SCTC_SRC_RSVD = 2'b11
	} sctc_src_e;

	typedef struct packed {
		logic [7:0] adr;
		logic [31:0] dat;
		logic [3:0] sel;
		logic we;
		logic stb;
		logic cyc;
	} sctc_wb_req_s;

	typedef struct packed {
		logic [5:0] mul_factor;
		logic [9:0] ahb_div;
		logic [4:0] apb1_div;
		logic [4:0] apb2_div;
		logic [4:0] adc_div;
		logic adc_from_ahb;
		logic pll_div2;
		logic [1:0] pll_input;
	} sctc_tree_s;

endpackage

// file: hdl/sctc_top.sv
/*
 * System clock tree control: configuration registers, source switch with
 * status readback and forced fallback, stable and stuck interrupt flags.
 * Assumes a classic Wishbone master on clk; oscillator status inputs are
 * asynchronous and are synchronised here.
 */
// Local design decision: the Wishbone register port.
module sctc_top (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_stb_i,
	input wire logic wb_cyc_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [4:0] osc_stable,
	input wire logic crystal_stuck,
	input wire logic wake_event,
	output logic clk_irq,
	output logic [1:0] sysclk_source,
	output logic sysclk_gate,
	output logic pll_enable,
	output sctc_pkg::sctc_tree_s tree
);

	// ------------------------------------------------------------
	// Input synchronisers
	// ------------------------------------------------------------
	// Three stages cost up to four cycles of flag latency; oscillator
	// status moves slowly, so the margin against metastability is cheap.
	logic [6:0] sync1_ff, sync2_ff, sync3_ff;
	logic [6:0] nxt_sync1, nxt_sync2, nxt_sync3;
	logic [6:0] seen_ff, nxt_seen;
	logic [6:0] rise;

	always_comb begin
		nxt_sync1 = {wake_event, crystal_stuck, osc_stable};
		nxt_sync2 = sync1_ff;
		nxt_sync3 = sync2_ff;
		nxt_seen = seen_ff;
		// A level counts once the second and third stages agree
		for (int i = 0; i < 7; i++) begin
			if (sync2_ff[i] == sync3_ff[i]) begin
				nxt_seen[i] = sync3_ff[i];
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			sync1_ff <= '0;
			sync2_ff <= '0;
			sync3_ff <= '0;
			seen_ff <= '0;
		end else begin
			sync1_ff <= nxt_sync1;
			sync2_ff <= nxt_sync2;
			sync3_ff <= nxt_sync3;
			seen_ff <= nxt_seen;
		end
	end

	assign rise = nxt_seen & ~seen_ff;

	// ------------------------------------------------------------
	// Wishbone slave and registers
	// ------------------------------------------------------------
	logic [31:0] cfg0_ff, nxt_cfg0;
	logic [31:0] cfg1_ff, nxt_cfg1;
	logic [31:0] ctrl_ff, nxt_ctrl;
	logic [4:0] en_ff, nxt_en;
	logic [4:0] flag_ff, nxt_flag;
	logic stuck_ff, nxt_stuck;
	logic ack_ff, nxt_ack;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [1:0] status_ff;
	logic [31:0] bmask, int_word;
	logic wr, rd_go;
	logic force_rc;

	// A write lands at the taking edge, the same edge that raises ack,
	// so a read issued right behind it already returns the new value.
	assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !ack_ff;
	assign rd_go = wb_cyc_i && wb_stb_i && !ack_ff;

	// ------------------------------------------------------------
	// Stable events, one per oscillator
	// ------------------------------------------------------------
	// Only a fresh rise arms a flag; a source already stable when its
	// enable is set raises nothing, which software has to allow for.
	logic [sctc_pkg::NSRC-1:0] stable_set;

	for (genvar g = 0; g < sctc_pkg::NSRC; g++) begin : g_stable
		assign stable_set[g] = rise[g] && en_ff[g];
	end

	// Byte lanes of the write mask follow the byte selects
	for (genvar b = 0; b < 4; b++) begin : g_lane
		assign bmask[b*8 +: 8] = {8{wb_sel_i[b]}};
	end

	// Clear bits are write-only and reserved bits stay zero on reads
	assign int_word = {8'h00, 3'h0, 5'h00, 3'h0, en_ff, stuck_ff, 2'b00, flag_ff};

	// ------------------------------------------------------------
	// Forced fallback
	// ------------------------------------------------------------
	// Judged on the source in use, not the one asked for, so a failure
	// during a switch towards the crystal acts once that switch is done.
	logic xtal_in_use;

	assign xtal_in_use = status_ff == sctc_pkg::SCTC_SRC_XTAL ||
		(status_ff == sctc_pkg::SCTC_SRC_PLL && cfg0_ff[sctc_pkg::PSRC_BIT] &&
		!cfg1_ff[sctc_pkg::PRESEL_BIT]);
	// Failure is a level: the fallback holds while the crystal is in use
	assign force_rc = rise[6] || (seen_ff[5] && xtal_in_use);

	always_comb begin
		nxt_cfg0 = cfg0_ff;
		nxt_cfg1 = cfg1_ff;
		nxt_ctrl = ctrl_ff;
		nxt_en = en_ff;
		nxt_flag = flag_ff;
		nxt_stuck = stuck_ff;
		nxt_ack = rd_go;
		nxt_rdata = rdata_ff;
		if (wr) begin
			unique case (wb_adr_i)
				sctc_pkg::CFG0_ADDR: begin
					nxt_cfg0 = (cfg0_ff & ~(bmask & sctc_pkg::CFG0_WMASK)) |
						(wb_dat_i & bmask & sctc_pkg::CFG0_WMASK);
					// Pre-divide held while the PLL runs, guarding software slips
					if (ctrl_ff[sctc_pkg::PLL_EN_BIT]) begin
						nxt_cfg0[sctc_pkg::PDIV_BIT] = cfg0_ff[sctc_pkg::PDIV_BIT];
					end
				end
				sctc_pkg::CFG1_ADDR: begin
					nxt_cfg1 = (cfg1_ff & ~(bmask & sctc_pkg::CFG1_WMASK)) |
						(wb_dat_i & bmask & sctc_pkg::CFG1_WMASK);
				end
				sctc_pkg::CTRL_ADDR: begin
					nxt_ctrl = (ctrl_ff & ~(bmask & sctc_pkg::CTRL_WMASK)) |
						(wb_dat_i & bmask & sctc_pkg::CTRL_WMASK);
				end
				sctc_pkg::INT_ADDR: begin
					if (wb_sel_i[1]) begin
						nxt_en = wb_dat_i[sctc_pkg::EN_LSB +: 5];
					end
					if (wb_sel_i[2]) begin
						nxt_flag = flag_ff & ~wb_dat_i[sctc_pkg::CLR_LSB +: 5];
						if (wb_dat_i[sctc_pkg::STUCK_CLR_BIT]) begin
							nxt_stuck = 1'b0;
						end
					end
				end
				default: begin
				end
			endcase
		end
		if (force_rc) begin
			nxt_cfg0[sctc_pkg::SW_LSB +: 2] = sctc_pkg::SCTC_SRC_RC8M;
		end
		// Setting wins over a clear in the same cycle
		nxt_flag = nxt_flag | stable_set;
		if (rise[5]) begin
			nxt_stuck = 1'b1;
		end
		if (rd_go) begin
			unique case (wb_adr_i)
				sctc_pkg::CFG0_ADDR: nxt_rdata = {cfg0_ff[31:4], status_ff, cfg0_ff[1:0]};
				sctc_pkg::INT_ADDR: nxt_rdata = int_word;
				sctc_pkg::CFG1_ADDR: nxt_rdata = cfg1_ff;
				sctc_pkg::CTRL_ADDR: nxt_rdata = ctrl_ff;
				default: nxt_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cfg0_ff <= sctc_pkg::CFG0_RESET;
			cfg1_ff <= sctc_pkg::CFG1_RESET;
			ctrl_ff <= sctc_pkg::CTRL_RESET;
			en_ff <= sctc_pkg::INT_RESET[sctc_pkg::EN_LSB +: 5];
			flag_ff <= sctc_pkg::INT_RESET[sctc_pkg::FLAG_LSB +: 5];
			stuck_ff <= sctc_pkg::INT_RESET[sctc_pkg::STUCK_FLAG_BIT];
			ack_ff <= 1'b0;
			rdata_ff <= 32'h0000_0000;
		end else begin
			cfg0_ff <= nxt_cfg0;
			cfg1_ff <= nxt_cfg1;
			ctrl_ff <= nxt_ctrl;
			en_ff <= nxt_en;
			flag_ff <= nxt_flag;
			stuck_ff <= nxt_stuck;
			ack_ff <= nxt_ack;
			rdata_ff <= nxt_rdata;
		end
	end

	// ------------------------------------------------------------
	// Source switch
	// ------------------------------------------------------------
	// The clock is gated for a gap so no cut pulse reaches the tree,
	// then the new source is used, then status reports it.
	// Code 11 is stored in the switch field but never acted on; the
	// running source stays until a legal code is written.
	typedef enum logic [1:0] {SCTC_IDLE, SCTC_GATE, SCTC_USE} sctc_sw_state_e;
	sctc_sw_state_e st_ff, nxt_st;
	logic [3:0] cnt_ff, nxt_cnt;
	logic [1:0] src_ff, nxt_src;
	logic [1:0] nxt_status;
	logic gate_ff, nxt_gate;
	logic irq_ff, nxt_irq;
	logic [1:0] req;

	assign req = cfg0_ff[sctc_pkg::SW_LSB +: 2];

	always_comb begin
		nxt_st = st_ff;
		nxt_cnt = cnt_ff;
		nxt_src = src_ff;
		nxt_status = status_ff;
		nxt_gate = gate_ff;
		unique case (st_ff)
			SCTC_IDLE: begin
				if (req != src_ff && req != sctc_pkg::SCTC_SRC_RSVD) begin
					nxt_st = SCTC_GATE;
					nxt_gate = 1'b0;
					nxt_cnt = sctc_pkg::SWITCH_GAP;
				end
			end
			SCTC_GATE: begin
				nxt_cnt = 4'(cnt_ff - 4'h1);
				if (cnt_ff == 4'h1) begin
					// A reserved code written mid-gate keeps the running source
					if (req != sctc_pkg::SCTC_SRC_RSVD) begin
						nxt_src = req;
					end
					nxt_st = SCTC_USE;
				end
			end
			SCTC_USE: begin
				nxt_gate = 1'b1;
				// Status trails the source by a cycle so a poll never runs ahead
				nxt_status = src_ff;
				nxt_st = SCTC_IDLE;
			end
		endcase
		nxt_irq = |nxt_flag || nxt_stuck;
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			st_ff <= SCTC_IDLE;
			cnt_ff <= 4'h0;
			src_ff <= sctc_pkg::SCTC_SRC_RC8M;
			status_ff <= sctc_pkg::SCTC_SRC_RC8M;
			gate_ff <= 1'b1;
			irq_ff <= 1'b0;
		end else begin
			st_ff <= nxt_st;
			cnt_ff <= nxt_cnt;
			src_ff <= nxt_src;
			status_ff <= nxt_status;
			gate_ff <= nxt_gate;
			irq_ff <= nxt_irq;
		end
	end

	// ------------------------------------------------------------
	// Factor decode
	// ------------------------------------------------------------
	sctc_div_decode u_decode (
		.clk(clk),
		.nrst(nrst),
		.mul_code({cfg0_ff[sctc_pkg::MUL5_BIT], cfg0_ff[sctc_pkg::MUL4_BIT],
			cfg0_ff[sctc_pkg::MUL_LSB +: 4]}),
		.ahb_code(cfg0_ff[sctc_pkg::AHB_LSB +: 4]),
		.apb1_code(cfg0_ff[sctc_pkg::APB1_LSB +: 3]),
		.apb2_code(cfg0_ff[sctc_pkg::APB2_LSB +: 3]),
		.adc_code({cfg1_ff[sctc_pkg::ADC3_BIT], cfg0_ff[sctc_pkg::ADC2_BIT],
			cfg0_ff[sctc_pkg::ADC_LSB +: 2]}),
		.pll_div(cfg0_ff[sctc_pkg::PDIV_BIT]),
		.pll_src(cfg0_ff[sctc_pkg::PSRC_BIT]),
		.pll_presel(cfg1_ff[sctc_pkg::PRESEL_BIT]),
		.tree(tree)
	);

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Every pin is a flop, so downstream gating and decode never see
	// a combinational glitch from the register logic.
	assign wb_dat_o = rdata_ff;
	assign wb_ack_o = ack_ff;
	assign clk_irq = irq_ff;
	assign sysclk_source = src_ff;
	assign sysclk_gate = gate_ff;
	assign pll_enable = ctrl_ff[sctc_pkg::PLL_EN_BIT];

endmodule

// file: verif/sctc_checker.sv
/*
 * Port checker of sctc_top: bus answer, source switch, interrupt line.
 * Assumes one clock domain and a classic Wishbone master.
 */
module sctc_checker (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_we_i,
	input wire logic wb_stb_i,
	input wire logic wb_cyc_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic clk_irq,
	input wire logic [1:0] sysclk_source,
	input wire logic sysclk_gate,
	input wire logic pll_enable
);
	// ----
	// Decode
	// ----
	logic take;
	logic wr0;
	logic clr;
	logic known;
	assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr0 = take && wb_we_i && wb_sel_i[0] && wb_adr_i == sctc_pkg::CFG0_ADDR;
	assign clr = take && wb_we_i && wb_sel_i[2] && wb_adr_i == sctc_pkg::INT_ADDR;
	assign known = wb_adr_i inside {sctc_pkg::CFG0_ADDR, sctc_pkg::INT_ADDR,
		sctc_pkg::CFG1_ADDR, sctc_pkg::CTRL_ADDR};
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);
	// Tree held off for the gap before the new source runs
	sequence s_gap;
		!sysclk_gate [*3] ##[1:6] sysclk_gate;
	endsequence
	// ----
	// Properties
	// ----
	a_ack_follows: assert property (take |=> wb_ack_o)
		else $error("no ack after request");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
		else $error("ack without request");
	a_unmapped_zero: assert property (take && !wb_we_i && !known |=> wb_dat_o == 32'h0)
		else $error("unmapped read not zero");
	a_src_legal: assert property (sysclk_source != 2'b11)
		else $error("reserved source");
	a_src_gated: assert property ($changed(sysclk_source) |-> !$past(sysclk_gate))
		else $error("source changed ungated");
	a_gate_gap: assert property ($fell(sysclk_gate) |-> s_gap)
		else $error("gate gap wrong");
	a_switch_start: assert property (wr0 && sysclk_gate && wb_dat_i[1:0] != 2'b11 &&
		wb_dat_i[1:0] != sysclk_source |-> ##[1:3] !sysclk_gate)
		else $error("switch not started");
	a_irq_sticky: assert property ($fell(clk_irq) |-> $past(clr) || $past(clr, 2))
		else $error("interrupt dropped unasked");
	a_pll_write: assert property (take && wb_we_i && wb_sel_i[0] &&
		wb_adr_i == sctc_pkg::CTRL_ADDR |=> pll_enable == $past(wb_dat_i[0]))
		else $error("pll enable not written");
endmodule

bind sctc_top sctc_checker sctc_checker_i (.*);

// file: verif/test_system_clock_tree_control.sv
/*
 * Self-checking bench of sctc_top: registers, tree decode, switch, flags.
 * Assumes the checker is bound from its own file.
 */
module test_system_clock_tree_control;
	timeunit 1ns;
	timeprecision 1ps;
	// ----
	// Signals
	// ----
	logic clk = 1'b0;
	logic nrst = 1'b0;
	sctc_pkg::sctc_wb_req_s req = '0;
	logic [4:0] osc = 5'h0;
	logic stuck = 1'b0;
	logic wake = 1'b0;
	logic [31:0] dat_o;
	logic ack;
	logic irq;
	logic [1:0] src;
	logic gate;
	logic pll_en;
	sctc_pkg::sctc_tree_s tree;
	logic [63:0] notes[$];
	logic [63:0] m;
	logic [31:0] cfg0 = 32'h0;
	logic [31:0] cfg1 = 32'h0;
	logic [4:0] r;
	logic [1:0] sw_seq[4] = '{2'h1, 2'h2, 2'h3, 2'h0};
	logic [1:0] sw_exp[4] = '{2'h1, 2'h2, 2'h2, 2'h0};
	int adc_lo[8] = '{2, 4, 6, 8, 2, 12, 8, 16};
	int adc_hi[4] = '{5, 6, 10, 20};
	int failures = 0;
	int n_checks = 0;
	int cyc_n = 0;

	always #2 clk = ~clk;

	sctc_top sctc_top_i (
		.clk(clk), .nrst(nrst), .wb_adr_i(req.adr), .wb_dat_i(req.dat),
		.wb_sel_i(req.sel), .wb_we_i(req.we), .wb_stb_i(req.stb), .wb_cyc_i(req.cyc),
		.wb_dat_o(dat_o), .wb_ack_o(ack), .osc_stable(osc), .crystal_stuck(stuck),
		.wake_event(wake), .clk_irq(irq), .sysclk_source(src), .sysclk_gate(gate),
		.pll_enable(pll_en), .tree(tree)
	);

	// ----
	// Tasks
	// ----
	task automatic results();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// A read carries its expected value on the data lines, which it ignores
	task automatic bus(input logic [7:0] a, input logic [31:0] d, input logic w,
		input logic [3:0] s, input logic [31:0] mk);
		if (!w)
			notes.push_back({mk, d & mk});
		req <= '{a, d, s, w, 1'b1, 1'b1};
		do
			@(posedge clk);
		while (ack !== 1'b1);
		req.stb <= 1'b0;
		req.cyc <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		bus(a, d, 1'b1, s, 32'h0);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] mk, input logic [31:0] e);
		bus(a, e, 1'b0, 4'hf, mk);
	endtask

	task automatic wait_src(input logic [1:0] e);
		for (int n = 0; n < 40 && src !== e; n++)
			@(posedge clk);
		repeat (3) @(posedge clk);
		check(src, e);
	endtask

	function automatic logic [5:0] mul_f(input logic [5:0] c);
		if (c < 6'h0f)
			return c + 6'h02;
		if (c == 6'h0f)
			return 6'h10;
		if (c > 6'h3d)
			return 6'h3f;
		return c + 6'h01;
	endfunction

	task automatic chk_tree();
		logic [3:0] adc;
		adc = {cfg1[29], cfg0[28], cfg0[15:14]};
		check(tree.mul_factor, mul_f({cfg0[30], cfg0[27], cfg0[21:18]}));
		check(tree.ahb_div, cfg0[7] ? 32'h1 << (cfg0[6:4] + 1 + cfg0[6]) : 32'h1);
		check(tree.apb1_div, cfg0[10] ? 32'h2 << cfg0[9:8] : 32'h1);
		check(tree.apb2_div, cfg0[13] ? 32'h2 << cfg0[12:11] : 32'h1);
		check(tree.adc_div, adc[3] ? adc_hi[adc[1:0]] : adc_lo[adc[2:0]]);
		check(tree.adc_from_ahb, adc[3]);
		check(tree.pll_div2, cfg0[17]);
		check(tree.pll_input, !cfg0[16] ? 2'h0 : cfg1[30] ? 2'h2 : 2'h1);
	endtask

	// ----
	// Checking and sequence
	// ----
	always @(negedge clk)
		if (ack === 1'b1 && req.we === 1'b0) begin
			m = notes.pop_front();
			check(dat_o & m[63:32], m[31:0]);
		end

	always @(posedge clk) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			failures++;
			results();
		end
	end

	initial begin
		void'($urandom(32'hf322));
		repeat (6) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		rd(sctc_pkg::INT_ADDR, 32'hffff_ffff, 32'h0);
		rd(sctc_pkg::CFG0_ADDR, 32'hffff_ffff, 32'h0);
		rd(8'h10, 32'hffff_ffff, 32'h0);
		chk_tree();
		for (int i = 0; i < 64; i++) begin
			// Only factors are formed here, so no switch code can start a switch
			cfg0 = $urandom() & 32'h583f_fff0;
			{cfg0[30], cfg0[27], cfg0[21:18]} = i[5:0];
			cfg1 = $urandom() & 32'h6000_0000;
			wr(sctc_pkg::CFG1_ADDR, cfg1, 4'hf);
			wr(sctc_pkg::CFG0_ADDR, cfg0, 4'hf);
			repeat (3) @(posedge clk);
			chk_tree();
			rd(sctc_pkg::CFG0_ADDR, 32'hfbff_fff3, cfg0);
		end
		// Pre-divide write must be refused while the PLL runs
		wr(sctc_pkg::CTRL_ADDR, 32'h1, 4'h1);
		rd(sctc_pkg::CTRL_ADDR, 32'h1, 32'h1);
		wr(sctc_pkg::CFG0_ADDR, cfg0 ^ 32'h0002_0000, 4'hf);
		repeat (3) @(posedge clk);
		chk_tree();
		wr(sctc_pkg::CTRL_ADDR, 32'h0, 4'h1);
		foreach (sw_seq[k]) begin
			wr(sctc_pkg::CFG0_ADDR, cfg0 | sw_seq[k], 4'h1);
			wait_src(sw_exp[k]);
			rd(sctc_pkg::CFG0_ADDR, 32'hc, {28'h0, sw_exp[k], 2'h0});
		end
		// A reserved code landing mid-switch keeps the running source
		wr(sctc_pkg::CFG0_ADDR, cfg0 | 32'h1, 4'h1);
		wr(sctc_pkg::CFG0_ADDR, cfg0 | 32'h3, 4'h1);
		wait_src(2'h0);
		wr(sctc_pkg::CFG0_ADDR, cfg0 | 32'h1, 4'h1);
		wait_src(2'h1);
		stuck <= 1'b1;
		wait_src(2'h0);
		check(irq, 1'b1);
		stuck <= 1'b0;
		wr(sctc_pkg::INT_ADDR, 32'h0, 4'h4);
		rd(sctc_pkg::INT_ADDR, 32'h9f, 32'h80);
		wr(sctc_pkg::INT_ADDR, 32'h0080_0000, 4'h4);
		rd(sctc_pkg::INT_ADDR, 32'h9f, 32'h0);
		// Crystal failure also forces the fallback while it feeds the PLL
		cfg0[16] = 1'b1;
		cfg1[30] = 1'b0;
		wr(sctc_pkg::CFG1_ADDR, cfg1, 4'hf);
		wr(sctc_pkg::CFG0_ADDR, cfg0 | 32'h2, 4'hf);
		wait_src(2'h2);
		chk_tree();
		stuck <= 1'b1;
		wait_src(2'h0);
		stuck <= 1'b0;
		wr(sctc_pkg::INT_ADDR, 32'h0080_0000, 4'h4);
		wr(sctc_pkg::CFG0_ADDR, cfg0 | 32'h2, 4'h1);
		wait_src(2'h2);
		wake <= 1'b1;
		wait_src(2'h0);
		wake <= 1'b0;
		osc <= 5'h1f;
		repeat (8) @(posedge clk);
		osc <= 5'h0;
		rd(sctc_pkg::INT_ADDR, 32'h1f9f, 32'h0);
		r = 5'($urandom()) | 5'h1;
		wr(sctc_pkg::INT_ADDR, 32'h1f00, 4'h2);
		osc <= r;
		repeat (8) @(posedge clk);
		rd(sctc_pkg::INT_ADDR, 32'h1f9f, {19'h0, 5'h1f, 3'h0, r});
		check(irq, 1'b1);
		for (int i = 0; i < 5; i++) begin
			wr(sctc_pkg::INT_ADDR, 32'h1 << (16 + i), 4'h4);
			rd(sctc_pkg::INT_ADDR, 32'h1f9f, {19'h0, 5'h1f, 3'h0, r & ~((5'h2 << i) - 5'h1)});
		end
		check(irq, 1'b0);
		results();
	end
endmodule
